//--- rtl/ppfm_defs.vh
// Constants and register address list for the port pin function multiplexer
`ifndef PPFM_DEFS_VH
`define PPFM_DEFS_VH
`define PPFM_A_P0_LATCH 5'h00
`define PPFM_A_P0_DIR 5'h01
`define PPFM_A_P0_FSEL 5'h02
`define PPFM_A_P2_READ 5'h03
`define PPFM_A_P3_LATCH 5'h04
`define PPFM_A_P3_DIR 5'h05
`define PPFM_A_P3_FSEL 5'h06
`define PPFM_A_P4_LATCH 5'h07
`define PPFM_A_MEM_MODE 5'h08
`define PPFM_A_P5_LATCH 5'h09
`define PPFM_A_P5_DIR 5'h0a
`define PPFM_A_P7_READ 5'h0b
`define PPFM_A_P8_LATCH 5'h0c
`define PPFM_A_P8_DIR 5'h0d
`define PPFM_A_P8_FSEL 5'h0e
`define PPFM_A_P9_LATCH 5'h0f
`define PPFM_A_P9_DIR 5'h10
`define PPFM_A_CTRL 5'h11
`define PPFM_DIR_RST 8'hff
`define PPFM_FSEL_RST 8'h00
`define PPFM_MM_RST 8'h00
`define PPFM_MM_P4OUT_BIT 0
`define PPFM_CTRL_P05_PWM_BIT 0
`define PPFM_CTRL_P06_TMR_BIT 1
`define PPFM_CTRL_SBI_BIT 2
`define PPFM_CTRL_RST 8'h00
`endif

//--- rtl/ppfm_sync.v
// Three-stage input synchroniser with agreement check and edge output
`timescale 1ns/10ps
`default_nettype none
module ppfm_sync (
  input wire clock,
  input wire rst,
  input wire din,
  output reg level,
  output reg rise,
  output reg fall
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clock) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2_r == s3_r && s3_r != level) begin
        level <= s3_r;
        rise <= s3_r;
        fall <= ~s3_r;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/ppfm_pin.v
// One bidirectional pin: port or control mode output selection
`timescale 1ns/10ps
`default_nettype none
module ppfm_pin (
  input wire clock,
  input wire rst,
  input wire ctrl_mode,
  input wire port_dir_in,
  input wire port_latch,
  input wire ctrl_oe,
  input wire ctrl_val,
  output reg pin_o,
  output reg pin_oe
);
  always @(posedge clock) begin
    if (rst) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ctrl_mode) begin
      pin_o <= ctrl_val;
      pin_oe <= ctrl_oe;
    end else begin
      pin_o <= port_latch;
      pin_oe <= ~port_dir_in;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ppfm_top.v
// Port and pin function multiplexer top level
`timescale 1ns/10ps
`default_nettype none
`include "ppfm_defs.vh"
module ppfm_top (
  input wire clock,
  input wire rst,
  input wire reset_n_pin,
  input wire mode_pin,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg sys_reset,
  input wire [7:0] port0_pins_i,
  output wire [7:0] port0_pins_o,
  output wire [7:0] port0_pins_oe,
  input wire [5:0] port2_pins,
  input wire [4:0] port3_pins_i,
  output wire [4:0] port3_pins_o,
  output wire [4:0] port3_pins_oe,
  input wire [7:0] port4_pins_i,
  output wire [7:0] port4_pins_o,
  output wire [7:0] port4_pins_oe,
  input wire [7:0] port5_pins_i,
  output wire [7:0] port5_pins_o,
  output wire [7:0] port5_pins_oe,
  input wire [7:0] port7_pins,
  input wire [5:0] port8_pins_i,
  output wire [5:0] port8_pins_o,
  output wire [5:0] port8_pins_oe,
  input wire [2:0] port9_pins_i,
  output wire [2:0] port9_pins_o,
  output wire [2:0] port9_pins_oe,
  input wire [3:0] realtime_out_data,
  input wire realtime_trigger,
  input wire pulse_width_out_a,
  input wire pulse_width_out_b,
  input wire timer4_out,
  input wire [5:0] timer0_outs,
  input wire uart_tx,
  input wire csi_out,
  input wire csi_out_oe,
  input wire csi_line_one_out,
  input wire csi_line_one_oe,
  input wire csi_clock_out,
  input wire csi_clock_oe,
  output reg [3:0] realtime_out_pins,
  output reg nmi_edge,
  output reg [4:0] ext_irq_rise,
  output reg [4:0] ext_irq_fall,
  output reg external_count_input_one,
  output reg updown_clock_in,
  output reg updown_dir_select,
  output reg updown_clear_in,
  output reg uart_rx,
  output reg csi_in,
  output reg csi_clock_in,
  output reg two_line_bus_mode,
  output reg [7:0] analog_inputs
);
  reg [7:0] p0_latch_r;
  reg [7:0] port0_direction_reg;
  reg [7:0] port0_function_select;
  reg [4:0] p3_latch_r;
  reg [4:0] port3_direction_reg;
  reg [4:0] port3_function_select;
  reg [7:0] p4_latch_r;
  reg [7:0] memory_expansion_mode_reg;
  reg [7:0] p5_latch_r;
  reg [7:0] port5_direction_reg;
  reg [5:0] p8_latch_r;
  reg [5:0] port8_direction_reg;
  reg [5:0] port8_function_select;
  reg [2:0] p9_latch_r;
  reg [2:0] port9_direction_reg;
  reg [7:0] ctrl_r;
  reg [3:0] rt_hold_r;
  reg [7:0] rdata_nxt;
  // Pin synchronisers
  wire [5:0] p2_lvl;
  wire [5:0] p2_rise;
  wire [5:0] p2_fall;
  wire [7:0] p0_lvl;
  wire [4:0] p3_lvl;
  wire [7:0] p4_lvl;
  wire [7:0] p5_lvl;
  wire [7:0] p7_lvl;
  wire [5:0] p8_lvl;
  wire [2:0] p9_lvl;
  wire rst_lvl;
  wire [52:0] all_pins;
  wire [52:0] all_lvl;
  wire [52:0] all_rise;
  wire [52:0] all_fall;
  // Synchroniser slot map
  assign all_pins[5:0] = port2_pins;
  assign all_pins[13:6] = port0_pins_i;
  assign all_pins[18:14] = port3_pins_i;
  assign all_pins[26:19] = port4_pins_i;
  assign all_pins[34:27] = port5_pins_i;
  assign all_pins[42:35] = port7_pins;
  assign all_pins[48:43] = port8_pins_i;
  assign all_pins[51:49] = port9_pins_i;
  assign all_pins[52] = reset_n_pin;
  assign p2_lvl = all_lvl[5:0];
  assign p0_lvl = all_lvl[13:6];
  assign p3_lvl = all_lvl[18:14];
  assign p4_lvl = all_lvl[26:19];
  assign p5_lvl = all_lvl[34:27];
  assign p7_lvl = all_lvl[42:35];
  assign p8_lvl = all_lvl[48:43];
  assign p9_lvl = all_lvl[51:49];
  assign rst_lvl = all_lvl[52];
  assign p2_rise = all_rise[5:0];
  assign p2_fall = all_fall[5:0];
  genvar gi;
  generate
    for (gi = 0; gi < 53; gi = gi + 1) begin : g_sync
      ppfm_sync u_sync (
        .clock(clock),
        .rst(rst),
        .din(all_pins[gi]),
        .level(all_lvl[gi]),
        .rise(all_rise[gi]),
        .fall(all_fall[gi])
      );
    end
  endgenerate
  // Register writes
  always @(posedge clock) begin
    if (rst || sys_reset) begin
      p0_latch_r <= 8'h00;
      port0_direction_reg <= `PPFM_DIR_RST;
      port0_function_select <= `PPFM_FSEL_RST;
      p3_latch_r <= 5'h00;
      port3_direction_reg <= 5'h1f;
      port3_function_select <= 5'h00;
      p4_latch_r <= 8'h00;
      memory_expansion_mode_reg <= `PPFM_MM_RST;
      p5_latch_r <= 8'h00;
      port5_direction_reg <= `PPFM_DIR_RST;
      p8_latch_r <= 6'h00;
      port8_direction_reg <= 6'h3f;
      port8_function_select <= 6'h00;
      p9_latch_r <= 3'h0;
      port9_direction_reg <= 3'h7;
      ctrl_r <= `PPFM_CTRL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `PPFM_A_P0_LATCH: p0_latch_r <= reg_wdata;
        `PPFM_A_P0_DIR: port0_direction_reg <= reg_wdata;
        `PPFM_A_P0_FSEL: port0_function_select <= reg_wdata;
        `PPFM_A_P3_LATCH: p3_latch_r <= reg_wdata[4:0];
        `PPFM_A_P3_DIR: port3_direction_reg <= reg_wdata[4:0];
        `PPFM_A_P3_FSEL: port3_function_select <= reg_wdata[4:0];
        `PPFM_A_P4_LATCH: p4_latch_r <= reg_wdata;
        `PPFM_A_MEM_MODE: memory_expansion_mode_reg <= reg_wdata;
        `PPFM_A_P5_LATCH: p5_latch_r <= reg_wdata;
        `PPFM_A_P5_DIR: port5_direction_reg <= reg_wdata;
        `PPFM_A_P8_LATCH: p8_latch_r <= reg_wdata[5:0];
        `PPFM_A_P8_DIR: port8_direction_reg <= reg_wdata[5:0];
        `PPFM_A_P8_FSEL: port8_function_select <= reg_wdata[5:0];
        `PPFM_A_P9_LATCH: p9_latch_r <= reg_wdata[2:0];
        `PPFM_A_P9_DIR: port9_direction_reg <= reg_wdata[2:0];
        `PPFM_A_CTRL: ctrl_r <= reg_wdata;
        default: ;
      endcase
    end
  end
  // Register reads, data one cycle after strobe
  always @* begin
    case (reg_addr)
      `PPFM_A_P0_LATCH: rdata_nxt = p0_lvl;
      `PPFM_A_P0_DIR: rdata_nxt = port0_direction_reg;
      `PPFM_A_P0_FSEL: rdata_nxt = port0_function_select;
      `PPFM_A_P2_READ: rdata_nxt = {2'h0, p2_lvl};
      `PPFM_A_P3_LATCH: rdata_nxt = {3'h0, p3_lvl};
      `PPFM_A_P3_DIR: rdata_nxt = {3'h0, port3_direction_reg};
      `PPFM_A_P3_FSEL: rdata_nxt = {3'h0, port3_function_select};
      `PPFM_A_P4_LATCH: rdata_nxt = p4_lvl;
      `PPFM_A_MEM_MODE: rdata_nxt = memory_expansion_mode_reg;
      `PPFM_A_P5_LATCH: rdata_nxt = p5_lvl;
      `PPFM_A_P5_DIR: rdata_nxt = port5_direction_reg;
      `PPFM_A_P7_READ: rdata_nxt = p7_lvl;
      `PPFM_A_P8_LATCH: rdata_nxt = {2'h0, p8_lvl};
      `PPFM_A_P8_DIR: rdata_nxt = {2'h0, port8_direction_reg};
      `PPFM_A_P8_FSEL: rdata_nxt = {2'h0, port8_function_select};
      `PPFM_A_P9_LATCH: rdata_nxt = {5'h00, p9_lvl};
      `PPFM_A_P9_DIR: rdata_nxt = {5'h00, port9_direction_reg};
      `PPFM_A_CTRL: rdata_nxt = ctrl_r;
      default: rdata_nxt = 8'h00;
    endcase
  end
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
  // Reset pin, realtime outputs and routed control inputs
  always @(posedge clock) begin
    if (rst) begin
      sys_reset <= 1'b1;
      rt_hold_r <= 4'h0;
      realtime_out_pins <= 4'h0;
      nmi_edge <= 1'b0;
      ext_irq_rise <= 5'h00;
      ext_irq_fall <= 5'h00;
      external_count_input_one <= 1'b0;
      updown_clock_in <= 1'b0;
      updown_dir_select <= 1'b0;
      updown_clear_in <= 1'b0;
      uart_rx <= 1'b1;
      csi_in <= 1'b0;
      csi_clock_in <= 1'b0;
      two_line_bus_mode <= 1'b0;
      analog_inputs <= 8'h00;
    end else begin
      sys_reset <= ~rst_lvl;
      if (realtime_trigger) begin
        rt_hold_r <= realtime_out_data;
      end
      realtime_out_pins <= rt_hold_r;
      nmi_edge <= p2_rise[0];
      ext_irq_rise <= p2_rise[5:1];
      ext_irq_fall <= p2_fall[5:1];
      external_count_input_one <= p2_lvl[4];
      updown_dir_select <= port0_function_select[5] & p0_lvl[5];
      updown_clock_in <= port0_function_select[6] & p0_lvl[6];
      updown_clear_in <= port0_function_select[7] & p0_lvl[7];
      uart_rx <= port3_function_select[1] ? p3_lvl[1] : 1'b1;
      csi_in <= port3_function_select[3] & p3_lvl[3];
      csi_clock_in <= port3_function_select[4] & p3_lvl[4];
      two_line_bus_mode <= ctrl_r[`PPFM_CTRL_SBI_BIT];
      analog_inputs <= p7_lvl;
    end
  end
  // Control-mode drive per pin
  reg [7:0] p0_coe;
  reg [7:0] p0_cval;
  reg [4:0] p3_coe;
  reg [4:0] p3_cval;
  always @* begin
    p0_cval[0] = rt_hold_r[0];
    p0_cval[1] = rt_hold_r[1];
    p0_cval[2] = rt_hold_r[2];
    p0_cval[3] = rt_hold_r[3];
    p0_cval[4] = pulse_width_out_a;
    p0_cval[5] = pulse_width_out_b;
    p0_cval[6] = timer4_out;
    p0_cval[7] = 1'b0;
    p0_coe = 8'h1f;
    p0_coe[5] = ctrl_r[`PPFM_CTRL_P05_PWM_BIT];
    p0_coe[6] = ctrl_r[`PPFM_CTRL_P06_TMR_BIT];
    p3_cval[0] = uart_tx;
    p3_cval[1] = 1'b0;
    p3_cval[2] = csi_out;
    p3_cval[3] = csi_line_one_out;
    p3_cval[4] = csi_clock_out;
    p3_coe[0] = 1'b1;
    p3_coe[1] = 1'b0;
    p3_coe[2] = 1'b1;
    p3_coe[3] = 1'b0;
    p3_coe[4] = csi_clock_oe;
    if (ctrl_r[`PPFM_CTRL_SBI_BIT]) begin
      p3_coe[2] = csi_out_oe;
      p3_coe[3] = csi_line_one_oe;
    end
  end
  wire [7:0] p4_dir_in;
  assign p4_dir_in = {8{~memory_expansion_mode_reg[`PPFM_MM_P4OUT_BIT]}};
  wire [37:0] m_ctrl;
  wire [37:0] m_dir;
  wire [37:0] m_lat;
  wire [37:0] m_coe;
  wire [37:0] m_cval;
  wire [37:0] m_o;
  wire [37:0] m_oe;
  // Pin slot map: p0 7:0, p3 12:8, p4 20:13, p5 28:21, p8 34:29, p9 37:35
  assign m_ctrl[7:0] = port0_function_select;
  assign m_ctrl[12:8] = port3_function_select;
  assign m_ctrl[20:13] = 8'h00;
  assign m_ctrl[28:21] = 8'h00;
  assign m_ctrl[34:29] = port8_function_select;
  assign m_ctrl[37:35] = 3'h0;
  assign m_dir[7:0] = port0_direction_reg;
  assign m_dir[12:8] = port3_direction_reg;
  assign m_dir[20:13] = p4_dir_in;
  assign m_dir[28:21] = port5_direction_reg;
  assign m_dir[34:29] = port8_direction_reg;
  assign m_dir[37:35] = port9_direction_reg;
  assign m_lat[7:0] = p0_latch_r;
  assign m_lat[12:8] = p3_latch_r;
  assign m_lat[20:13] = p4_latch_r;
  assign m_lat[28:21] = p5_latch_r;
  assign m_lat[34:29] = p8_latch_r;
  assign m_lat[37:35] = p9_latch_r;
  assign m_coe[7:0] = p0_coe;
  assign m_coe[12:8] = p3_coe;
  assign m_coe[20:13] = 8'h00;
  assign m_coe[28:21] = 8'h00;
  assign m_coe[34:29] = 6'h3f;
  assign m_coe[37:35] = 3'h0;
  assign m_cval[7:0] = p0_cval;
  assign m_cval[12:8] = p3_cval;
  assign m_cval[20:13] = 8'h00;
  assign m_cval[28:21] = 8'h00;
  assign m_cval[34:29] = timer0_outs;
  assign m_cval[37:35] = 3'h0;
  generate
    for (gi = 0; gi < 38; gi = gi + 1) begin : g_pin
      ppfm_pin u_pin (
        .clock(clock),
        .rst(rst | sys_reset),
        .ctrl_mode(m_ctrl[gi]),
        .port_dir_in(m_dir[gi]),
        .port_latch(m_lat[gi]),
        .ctrl_oe(m_coe[gi]),
        .ctrl_val(m_cval[gi]),
        .pin_o(m_o[gi]),
        .pin_oe(m_oe[gi])
      );
    end
  endgenerate
  assign port0_pins_o = m_o[7:0];
  assign port3_pins_o = m_o[12:8];
  assign port4_pins_o = m_o[20:13];
  assign port5_pins_o = m_o[28:21];
  assign port8_pins_o = m_o[34:29];
  assign port9_pins_o = m_o[37:35];
  assign port0_pins_oe = m_oe[7:0];
  assign port3_pins_oe = m_oe[12:8];
  assign port4_pins_oe = m_oe[20:13];
  assign port5_pins_oe = m_oe[28:21];
  assign port8_pins_oe = m_oe[34:29];
  assign port9_pins_oe = m_oe[37:35];
  wire mode_unused;
  assign mode_unused = mode_pin;
endmodule
`default_nettype wire

//--- tb/ppfm_props.sv
// Assertion checker for the port pin function multiplexer
`timescale 1ns/10ps
`default_nettype none
module ppfm_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sys_reset,
  input wire logic [7:0] port0_pins_oe,
  input wire logic [4:0] port3_pins_oe,
  input wire logic [7:0] port4_pins_oe,
  input wire logic [7:0] port5_pins_oe,
  input wire logic [5:0] port8_pins_oe,
  input wire logic [2:0] port9_pins_oe,
  input wire logic [3:0] realtime_out_data,
  input wire logic realtime_trigger,
  input wire logic [3:0] realtime_out_pins,
  input wire logic [4:0] ext_irq_rise
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  drivers_off_a: assert property (sys_reset |=> {port0_pins_oe, port3_pins_oe, port4_pins_oe,
    port5_pins_oe, port8_pins_oe, port9_pins_oe} == 38'h0) else $error("driver on in reset");
  rt_hold_a: assert property (!realtime_trigger && !sys_reset |=> ##1 $stable(realtime_out_pins))
    else $error("realtime pins moved without trigger");
  rt_load_a: assert property (realtime_trigger && !sys_reset |=> ##1
    realtime_out_pins == $past(realtime_out_data, 2)) else $error("realtime pins not loaded");
  irq_pulse_a: assert property (|ext_irq_rise |=> (ext_irq_rise & $past(ext_irq_rise)) == 5'h00)
    else $error("interrupt edge pulse too long");
  p2_width_a: assert property (reg_rd && reg_addr == 5'h03 |=> reg_rdata[7:6] == 2'b00)
    else $error("port 2 read too wide");
  p4_whole_a: assert property (port4_pins_oe == 8'h00 || port4_pins_oe == 8'hff)
    else $error("port 4 direction split");
  rst_enter_a: assert property (!reset_n_pin [*6] |=> sys_reset)
    else $error("reset pin low not seen");
  rst_leave_a: assert property (reset_n_pin [*6] |=> !sys_reset)
    else $error("reset pin high not seen");
  rt_c: cover property (realtime_trigger);
  irq_c: cover property (|ext_irq_rise);
  pinrst_c: cover property (sys_reset && !reset_n_pin);
endmodule
bind ppfm_top ppfm_props u_props (.*);
`default_nettype wire

//--- tb/ppfm_board.sv
// Board model: resolves bidirectional pins and holds the mode pin
`timescale 1ns/10ps
`default_nettype none
module ppfm_board (
  input wire logic [37:0] oe,
  input wire logic [37:0] o,
  input wire logic [37:0] ext,
  output logic [37:0] lvl,
  output logic mode_pin
);
  assign mode_pin = 1'b0;
  assign lvl = (oe & o) | (~oe & ext);
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock = 0, rst = 1, reset_n_pin = 1, reg_wr = 0, reg_rd = 0, sys_reset, mode_pin;
  logic [4:0] reg_addr = 0, port3_pins_i, port3_pins_o, port3_pins_oe, ext_irq_rise, ext_irq_fall;
  logic [7:0] reg_wdata = 0, reg_rdata, port0_pins_i, port0_pins_o, port0_pins_oe, port4_pins_i;
  logic [7:0] port4_pins_o, port4_pins_oe, port5_pins_i, port5_pins_o, port5_pins_oe, port7_pins = 0;
  logic [5:0] port2_pins = 0, port8_pins_i, port8_pins_o, port8_pins_oe, timer0_outs = 0;
  logic [2:0] port9_pins_i, port9_pins_o, port9_pins_oe, c;
  logic [3:0] realtime_out_data = 0, realtime_out_pins;
  logic realtime_trigger = 0, pulse_width_out_a = 0, pulse_width_out_b = 0, timer4_out = 0, uart_tx = 0;
  logic csi_out = 0, csi_out_oe = 0, csi_line_one_out = 0, csi_line_one_oe = 0, csi_clock_out = 0;
  logic csi_clock_oe = 0, nmi_edge, external_count_input_one, updown_clock_in, updown_dir_select;
  logic updown_clear_in, uart_rx, csi_in, csi_clock_in, two_line_bus_mode;
  logic [7:0] analog_inputs, l, d;
  logic [15:0] r;
  logic [37:0] oe, o, lvl, ext = 0;
  integer failures = 0, total_checks = 0, seed = 32'he778e303, cycles = 0, k, m;
  integer rises = 0, falls = 0, erise = 0, efall = 0, nrise = 0, enrise = 0;
  int la[5] = '{0, 4, 9, 12, 15};
  int da[5] = '{1, 5, 10, 13, 16};
  int lo[5] = '{0, 8, 21, 29, 35};
  logic [7:0] mk[5] = '{8'hff, 8'h1f, 8'hff, 8'h3f, 8'h07};
  assign oe = {port9_pins_oe, port8_pins_oe, port5_pins_oe, port4_pins_oe, port3_pins_oe, port0_pins_oe};
  assign o = {port9_pins_o, port8_pins_o, port5_pins_o, port4_pins_o, port3_pins_o, port0_pins_o};
  assign {port9_pins_i, port8_pins_i, port5_pins_i, port4_pins_i, port3_pins_i, port0_pins_i} = lvl;
  ppfm_top DUT (.*);
  ppfm_board u_board (.oe(oe), .o(o), .ext(ext), .lvl(lvl), .mode_pin(mode_pin));
  always #5 clock = ~clock;
  function automatic logic [7:0] sl(input logic [37:0] v, input int j);
    return (v >> lo[j]) & mk[j];
  endfunction
  task automatic finish_test;
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [37:0] seen, input logic [37:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    tick(1);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (!rst) begin
      rises += ext_irq_rise[0];
      falls += ext_irq_fall[0];
      nrise += nmi_edge;
    end
    if (cycles == 4000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    tick(8);
    rst <= 1'b0;
    tick(8);
    chk(oe, 38'h0);
    rd(5'h01, 8'hff);
    rd(5'h02, 8'h00);
    wr(5'h1f, 8'h5a);
    rd(5'h1f, 8'h00);
    for (k = 0; k < 20; k++) begin
      l = $random(seed);
      d = $random(seed);
      r = $random(seed);
      if (r[1] & !port2_pins[1]) erise++;
      if (!r[1] & port2_pins[1]) efall++;
      if (r[0] & !port2_pins[0]) enrise++;
      port2_pins <= r[5:0];
      port7_pins <= r[15:8];
      ext <= {$random(seed), $random(seed)};
      for (m = 0; m < 5; m++) begin
        wr(la[m], l);
        wr(da[m], d);
      end
      wr(5'h07, l);
      wr(5'h08, {7'h0, d[0]});
      tick(6);
      for (m = 0; m < 5; m++) begin
        chk(sl(oe, m), ~d & mk[m]);
        chk(sl(o & oe, m), l & ~d & mk[m]);
      end
      chk(port4_pins_oe, {8{d[0]}});
      chk(port4_pins_o & port4_pins_oe, l & {8{d[0]}});
      chk(analog_inputs, port7_pins);
      chk(external_count_input_one, port2_pins[4]);
      rd(5'h00, (l & ~d) | (ext[7:0] & d));
      rd(5'h03, {2'b00, port2_pins});
      rd(5'h0b, port7_pins);
    end
    chk(rises, erise);
    chk(falls, efall);
    chk(nrise, enrise);
    wr(5'h02, 8'hff);
    wr(5'h01, 8'h00);
    wr(5'h06, 8'h1f);
    wr(5'h0e, 8'h3f);
    for (k = 0; k < 8; k++) begin
      c = k[2:0];
      r = $random(seed);
      wr(5'h11, {5'h0, c});
      realtime_out_data <= r[3:0];
      realtime_trigger <= 1'b1;
      tick(1);
      realtime_trigger <= 1'b0;
      realtime_out_data <= ~r[3:0];
      {pulse_width_out_a, pulse_width_out_b, timer4_out, uart_tx, csi_out} <= r[8:4];
      {csi_line_one_out, csi_clock_out, csi_line_one_oe, csi_clock_oe} <= r[12:9];
      csi_out_oe <= c[0] | ~c[2];
      timer0_outs <= r[15:10];
      ext <= {$random(seed), $random(seed)};
      tick(8);
      chk(realtime_out_pins, r[3:0]);
      chk(port0_pins_oe, {1'b0, c[1:0], 5'h1f});
      chk(port0_pins_o & port0_pins_oe, {1'b0, c[1] & timer4_out, c[0] & pulse_width_out_b,
        pulse_width_out_a, r[3:0]});
      chk(updown_clear_in, ext[7]);
      if (!c[0]) chk(updown_dir_select, ext[5]);
      if (!c[1]) chk(updown_clock_in, ext[6]);
      chk(port3_pins_oe, {csi_clock_oe, c[2] & csi_line_one_oe, csi_out_oe, 2'b01});
      chk(port3_pins_o & port3_pins_oe, {csi_clock_oe & csi_clock_out, c[2] & csi_line_one_oe
        & csi_line_one_out, csi_out_oe & csi_out, 1'b0, uart_tx});
      chk(uart_rx, ext[9]);
      if (!c[2]) chk(csi_in, ext[11]);
      chk(csi_clock_in, csi_clock_oe ? csi_clock_out : ext[12]);
      chk(two_line_bus_mode, c[2]);
      chk(port8_pins_oe, 6'h3f);
      chk(port8_pins_o, timer0_outs);
    end
    reset_n_pin <= 1'b0;
    tick(10);
    chk(sys_reset, 1'b1);
    chk(oe, 38'h0);
    reset_n_pin <= 1'b1;
    tick(10);
    chk(sys_reset, 1'b0);
    rd(5'h02, 8'h00);
    rd(5'h0a, 8'hff);
    finish_test();
  end
endmodule
`default_nettype wire
